//--- shared/dsg_pkg.sv
// constants, register map and field layouts of the deep-sleep gating and soft reset block
`default_nettype none
package dsg_pkg;
	// ----------------------------------------------------------------
	// unit counts and indices
	// ----------------------------------------------------------------
	localparam int unsigned NUM_UNITS = 7;
	localparam int unsigned IDX_PORT_A = 0;
	localparam int unsigned IDX_PORT_E = 4;
	localparam int unsigned IDX_DMA = 5;
	localparam int unsigned IDX_USB = 6;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_SOFT_RESET = 12'h040;
	localparam logic [11:0] OFS_RUN_CFG = 12'h060;
	localparam logic [11:0] OFS_RUN_GATE = 12'h108;
	localparam logic [11:0] OFS_SLEEP_GATE = 12'h118;
	localparam logic [11:0] OFS_DEEP_GATE = 12'h128;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h150;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h154;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h158;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_USB_GATE = 16;
	localparam int unsigned BIT_DMA_GATE = 13;
	localparam int unsigned BIT_PORT_E_GATE = 4;
	localparam int unsigned BIT_CAN_RST = 24;
	localparam int unsigned BIT_ADC_RST = 16;
	localparam int unsigned BIT_HIB_RST = 6;
	localparam int unsigned BIT_WDT_RST = 3;
	localparam int unsigned BIT_AUTO_GATE = 27;
	// ----------------------------------------------------------------
	// implemented-bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] GATE_MASK = 32'h0001_201f;
	localparam logic [31:0] SOFT_RST_MASK = 32'h0101_0048;
	localparam logic [31:0] RUN_CFG_MASK = 32'h0800_0000;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam logic [31:0] SOFT_RST_RESET = 32'h0000_0000;
	localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
	localparam logic [6:0] UNIT_RESET = 7'h00;

	// unit vector to register layout: ports a..e low, dma, usb
	function automatic logic [31:0] dsg_pack(input logic [6:0] u);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[BIT_PORT_E_GATE:0] = u[IDX_PORT_E:IDX_PORT_A];
		r[BIT_DMA_GATE] = u[IDX_DMA];
		r[BIT_USB_GATE] = u[IDX_USB];
		return r;
	endfunction

	// register layout to unit vector
	function automatic logic [6:0] dsg_unpack(input logic [31:0] r);
		logic [6:0] u;
		u = UNIT_RESET;
		u[IDX_PORT_E:IDX_PORT_A] = r[BIT_PORT_E_GATE:0];
		u[IDX_DMA] = r[BIT_DMA_GATE];
		u[IDX_USB] = r[BIT_USB_GATE];
		return u;
	endfunction
endpackage
`default_nettype wire

//--- shared/dsg_gate_if.sv
// carrier between the register front end and the per-unit gate stage
`default_nettype none
interface dsg_gate_if;
	logic [6:0] run_set;
	logic [6:0] sleep_set;
	logic [6:0] deep_set;
	logic auto_gate;
	logic sleep_mode;
	logic deep_mode;
	logic [6:0] acc_valid;
	logic [6:0] clk_en;
	logic [6:0] fault;
	modport ctrl (
		output run_set, sleep_set, deep_set, auto_gate, sleep_mode, deep_mode, acc_valid,
		input clk_en, fault
	);
	modport gate (
		input run_set, sleep_set, deep_set, auto_gate, sleep_mode, deep_mode, acc_valid,
		output clk_en, fault
	);
endinterface
`default_nettype wire

//--- logic/dsg_gate_unit.sv
// per-unit clock enable selection and fault detection
`default_nettype none
module dsg_gate_unit
	import dsg_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// gate carrier
	dsg_gate_if.gate gif
);
	logic use_deep;
	logic use_sleep;

	// sleep sets govern only with auto gating on; deep wins over sleep
	assign use_deep = gif.auto_gate && gif.deep_mode; // see [RULE_06] see [RULE_07]
	assign use_sleep = gif.auto_gate && gif.sleep_mode && !gif.deep_mode; // see [RULE_07]

	// one enable flop per unit so a change lands on a clock edge only
	genvar g;
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : g_unit
			logic sel;
			always_comb begin
				if (use_deep) begin
					sel = gif.deep_set[g]; // see [RULE_01] see [RULE_02]
				end else if (use_sleep) begin
					sel = gif.sleep_set[g];
				end else begin
					sel = gif.run_set[g];
				end
			end
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					gif.clk_en[g] <= 1'b0; // see [RULE_04]
				end else begin
					gif.clk_en[g] <= sel; // see [RULE_16]
				end
			end
			// a gated unit answers any access with a fault
			assign gif.fault[g] = gif.acc_valid[g] && !gif.clk_en[g]; // see [RULE_03]
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_deep_set_used: assert property ( // see [RULE_06]
		@(posedge sys_clk) disable iff (sys_rst)
		(gif.auto_gate && gif.deep_mode) |=> (gif.clk_en == $past(gif.deep_set))
	) else $error("deep-sleep set not applied in deep sleep");

	chk_run_set_default: assert property ( // see [RULE_07]
		@(posedge sys_clk) disable iff (sys_rst)
		!gif.auto_gate |=> (gif.clk_en == $past(gif.run_set))
	) else $error("run set not in effect with auto gating off");

	chk_gated_fault: assert property ( // see [RULE_03]
		@(posedge sys_clk) disable iff (sys_rst)
		(gif.acc_valid & ~gif.clk_en) == gif.fault
	) else $error("access to gated unit without fault");

	chk_deep_bit_clock: assert property ( // see [RULE_01]
		@(posedge sys_clk) disable iff (sys_rst)
		(gif.auto_gate && gif.deep_mode && gif.deep_set[IDX_USB])[*2] |-> gif.clk_en[IDX_USB]
	) else $error("usb clock stopped although kept in deep sleep");
endmodule
`default_nettype wire

//--- logic/dsg_top.sv
// deep-sleep clock gating and software reset control with apb register access
// Behaviour
// [RULE_01] a set deep-sleep gating bit keeps that unit clocked in deep sleep
// [RULE_02] a clear gating bit stops the unit clock, unit disabled
// [RULE_03] accesses to a unit whose clock is gated answer with a bus fault
// [RULE_04] all gating bits are zero after reset, all units unclocked
// [RULE_05] software must set gating bits for the units it needs
// [RULE_06] separate run, sleep and deep-sleep sets; deep set only in deep sleep
// [RULE_07] sleep sets act only with auto gating set, otherwise run set
// [RULE_08] deep gate bit 16 usb, 13 dma, 4..0 ports e..a
// [RULE_09] reserved bits are read-only and read as zero
// [RULE_10] software keeps reserved bits in read-modify-write
// [RULE_11] soft reset writes are masked by capability presence bits
// [RULE_12] soft reset bit 24 resets can, bit 16 resets analog converter
// [RULE_13] soft reset bit 6 resets hibernation, bit 3 resets watchdog
// [RULE_14] soft reset register is read-write, resets to all zeros
// [RULE_15] a set reset bit holds the unit in reset, clearing releases it
// [RULE_16] gating and reset changes take effect on the system clock edge
`default_nettype none
module dsg_top
	import dsg_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power mode from the processor
	input wire logic sleep_mode,
	input wire logic deep_sleep_mode,
	// presence bits of the capability register
	input wire logic [31:0] capability_register_one,
	// unit access monitor
	input wire logic [6:0] unit_acc_valid,
	output logic [6:0] unit_acc_fault,
	// unit clock enables and resets
	output logic [6:0] unit_clk_en,
	output logic can_unit_reset,
	output logic adc_unit_reset,
	output logic hibernation_reset,
	output logic watchdog_reset,
	// interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0] soft_reset_control_zero_reg;
	logic [31:0] run_mode_clock_config_reg;
	logic [31:0] run_mode_clock_gate_two_reg;
	logic [31:0] sleep_mode_clock_gate_two_reg;
	logic [31:0] deep_sleep_clock_gate_two_reg;
	logic [6:0] irq_status_reg;
	logic [6:0] irq_status_next;
	logic [6:0] irq_enable_reg;
	logic [31:0] prdata_reg;
	logic err_reg;
	logic [31:0] rd_value;
	logic rd_hit;
	logic [31:0] byte_mask;
	logic setup_ph;
	logic wr_acc;
	logic [6:0] irq_clear;
	logic wr_soft;
	logic [31:0] soft_reset_next;

	dsg_gate_if gif ();

	// ----------------------------------------------------------------
	// apb phases
	// ----------------------------------------------------------------
	// zero wait states: every access phase completes on its first edge
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign pready = psel && penable;
	assign pslverr = psel && penable && err_reg;
	assign prdata = prdata_reg;

	// byte lanes widened into a bit mask
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign byte_mask[8*b+7:8*b] = {8{pstrb[b]}};
		end
	endgenerate

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	// reserved bits read as zero: gate, reset and config values are masked with their implemented-bit masks, irq registers are zero-extended
	always_comb begin
		rd_hit = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (paddr)
			OFS_SOFT_RESET: rd_value = soft_reset_control_zero_reg & SOFT_RST_MASK; // see [RULE_09]
			OFS_RUN_CFG: rd_value = run_mode_clock_config_reg & RUN_CFG_MASK;
			OFS_RUN_GATE: rd_value = run_mode_clock_gate_two_reg & GATE_MASK;
			OFS_SLEEP_GATE: rd_value = sleep_mode_clock_gate_two_reg & GATE_MASK;
			OFS_DEEP_GATE: rd_value = deep_sleep_clock_gate_two_reg & GATE_MASK; // see [RULE_09]
			OFS_IRQ_STATUS: rd_value = {25'h0, irq_status_reg};
			OFS_IRQ_ENABLE: rd_value = {25'h0, irq_enable_reg};
			OFS_IRQ_CLEAR: rd_value = 32'h0000_0000; // write-only, reads zero
			default: rd_hit = 1'b0;
		endcase
	end

	// read data and error are prepared in the setup phase so they come from flops
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (setup_ph) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_value;
			err_reg <= !rd_hit;
		end
	end

	// ----------------------------------------------------------------
	// software reset register
	// ----------------------------------------------------------------
	// absent units can never be put into reset: mask by presence bits
	assign wr_soft = wr_acc && (paddr == OFS_SOFT_RESET);
	assign soft_reset_next = ((soft_reset_control_zero_reg & ~byte_mask) | (pwdata & byte_mask))
		& capability_register_one & SOFT_RST_MASK; // see [RULE_11] see [RULE_09]

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			soft_reset_control_zero_reg <= SOFT_RST_RESET; // see [RULE_14]
		end else if (wr_soft) begin
			soft_reset_control_zero_reg <= soft_reset_next; // see [RULE_14] see [RULE_16]
		end
	end

	// reset lines straight from flops: a bit held high keeps its unit in reset
	assign can_unit_reset = soft_reset_control_zero_reg[BIT_CAN_RST]; // see [RULE_12] see [RULE_15]
	assign adc_unit_reset = soft_reset_control_zero_reg[BIT_ADC_RST]; // see [RULE_12] see [RULE_15]
	assign hibernation_reset = soft_reset_control_zero_reg[BIT_HIB_RST]; // see [RULE_13]
	assign watchdog_reset = soft_reset_control_zero_reg[BIT_WDT_RST]; // see [RULE_13] see [RULE_15]

	// ----------------------------------------------------------------
	// gating registers and run-mode clock configuration
	// ----------------------------------------------------------------
	// all three gate sets reset to zero; software enables what it needs
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_mode_clock_gate_two_reg <= GATE_RESET; // see [RULE_04]
			sleep_mode_clock_gate_two_reg <= GATE_RESET; // see [RULE_04]
			deep_sleep_clock_gate_two_reg <= GATE_RESET; // see [RULE_04]
		end else if (wr_acc) begin
			if (paddr == OFS_RUN_GATE) begin
				run_mode_clock_gate_two_reg <= ((run_mode_clock_gate_two_reg & ~byte_mask)
					| (pwdata & byte_mask)) & GATE_MASK;
			end
			if (paddr == OFS_SLEEP_GATE) begin
				sleep_mode_clock_gate_two_reg <= ((sleep_mode_clock_gate_two_reg & ~byte_mask)
					| (pwdata & byte_mask)) & GATE_MASK;
			end
			if (paddr == OFS_DEEP_GATE) begin
				deep_sleep_clock_gate_two_reg <= ((deep_sleep_clock_gate_two_reg & ~byte_mask)
					| (pwdata & byte_mask)) & GATE_MASK; // see [RULE_08] see [RULE_09]
			end
		end
	end

	// only the auto gating bit is implemented here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_mode_clock_config_reg <= RUN_CFG_RESET;
		end else if (wr_acc && (paddr == OFS_RUN_CFG)) begin
			run_mode_clock_config_reg <= ((run_mode_clock_config_reg & ~byte_mask)
				| (pwdata & byte_mask)) & RUN_CFG_MASK;
		end
	end

	// ----------------------------------------------------------------
	// gate stage
	// ----------------------------------------------------------------
	// field unpack maps usb, dma and ports e..a onto unit indices
	assign gif.run_set = dsg_unpack(run_mode_clock_gate_two_reg);
	assign gif.sleep_set = dsg_unpack(sleep_mode_clock_gate_two_reg);
	assign gif.deep_set = dsg_unpack(deep_sleep_clock_gate_two_reg); // see [RULE_08]
	assign gif.auto_gate = run_mode_clock_config_reg[BIT_AUTO_GATE]; // see [RULE_07]
	assign gif.sleep_mode = sleep_mode;
	assign gif.deep_mode = deep_sleep_mode;
	assign gif.acc_valid = unit_acc_valid;
	assign unit_clk_en = gif.clk_en;
	assign unit_acc_fault = gif.fault;

	dsg_gate_unit u_gate (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.gif(gif)
	);

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// a fault in the same cycle as its clear still lands: set wins
	assign irq_clear = (wr_acc && (paddr == OFS_IRQ_CLEAR)) ? pwdata[6:0] & byte_mask[6:0]
		: 7'h00;
	assign irq_status_next = (irq_status_reg & ~irq_clear) | unit_acc_fault;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status_reg <= UNIT_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_enable_reg <= UNIT_RESET;
		end else if (wr_acc && (paddr == OFS_IRQ_ENABLE) && pstrb[0]) begin
			irq_enable_reg <= pwdata[6:0];
		end
	end

	// level output, high while an enabled status bit is set
	assign irq = |(irq_status_reg & irq_enable_reg);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_soft_mask_cap: assert property ( // see [RULE_11]
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_soft && !capability_register_one[BIT_HIB_RST] && !hibernation_reset)
		|=> !hibernation_reset
	) else $error("reset bit of absent unit was set");

	chk_can_reset_write: assert property ( // see [RULE_12] see [RULE_15]
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_soft && pstrb[3] && capability_register_one[BIT_CAN_RST])
		|=> (can_unit_reset == $past(pwdata[BIT_CAN_RST]))
	) else $error("can reset does not follow its register bit");

	chk_wdt_reset_hold: assert property ( // see [RULE_13] see [RULE_15]
		@(posedge sys_clk) disable iff (sys_rst)
		(watchdog_reset && !wr_soft) |=> watchdog_reset
	) else $error("watchdog released without a write");

	chk_reserved_zero: assert property ( // see [RULE_09]
		@(posedge sys_clk) disable iff (sys_rst)
		(pready && !pwrite && (paddr == OFS_DEEP_GATE)) |-> ((prdata & ~GATE_MASK) == 32'h0)
	) else $error("reserved gate bits read as nonzero");

	chk_reset_values: assert property ( // see [RULE_04] see [RULE_14]
		@(posedge sys_clk)
		$fell(sys_rst) |-> (unit_clk_en == 7'h00 && soft_reset_control_zero_reg == 32'h0)
	) else $error("control state not zero after reset");

	chk_deep_map_usb: assert property ( // see [RULE_08]
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_acc && paddr == OFS_DEEP_GATE && pstrb[2])
		|=> (gif.deep_set[IDX_USB] == $past(pwdata[BIT_USB_GATE]))
	) else $error("deep gate usb bit not at its position");

	chk_irq_set_wins: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(unit_acc_fault[0] && irq_clear[0]) |=> irq_status_reg[0]
	) else $error("fault event lost against clear");

	chk_irq_level: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		irq == (|(irq_status_reg & irq_enable_reg))
	) else $error("irq does not match enabled status");

	chk_gate_edge_sync: assert property ( // see [RULE_16]
		@(posedge sys_clk) disable iff (sys_rst)
		(!gif.auto_gate && $changed(gif.run_set)) |-> (unit_clk_en == $past(gif.run_set))
	) else $error("clock enable changed before the clock edge");
endmodule
`default_nettype wire

//--- sim/test_dsg_top.sv
// self-checking testbench for the deep-sleep gating and soft reset block
`default_nettype none
module test_dsg_top import dsg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
	logic sleep_mode, deep_sleep_mode, can_unit_reset, adc_unit_reset;
	logic hibernation_reset, watchdog_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, capability_register_one, q;
	logic [3:0] pstrb;
	logic [6:0] unit_acc_valid, unit_acc_fault, unit_clk_en;
	int miscompares = 0;
	int checks = 0;
	int bp[7] = '{0, 1, 2, 3, 4, 13, 16};

	dsg_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.deep_sleep_mode(deep_sleep_mode), .capability_register_one(capability_register_one),
		.unit_acc_valid(unit_acc_valid), .unit_acc_fault(unit_acc_fault),
		.unit_clk_en(unit_clk_en), .can_unit_reset(can_unit_reset),
		.adc_unit_reset(adc_unit_reset), .hibernation_reset(hibernation_reset),
		.watchdog_reset(watchdog_reset), .irq(irq));

	// 250 mhz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; waits for pready under a bound, never assumes a latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask

	// lets register writes reach the gate flops before outputs are sampled
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [31:0] rst_outs();
		return {28'h0, can_unit_reset, adc_unit_reset, hibernation_reset, watchdog_reset};
	endfunction

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_reset_values();
		rd(OFS_DEEP_GATE, q);
		check("deep gate reset", q, 32'h0000_0000);
		rd(OFS_SOFT_RESET, q);
		check("soft reset reset", q, 32'h0000_0000);
		check("clk_en after reset", {25'h0, unit_clk_en}, 32'h0);
		check("reset outs after reset", rst_outs(), 32'h0);
	endtask

	// reserved bits stay zero, each field drives its own unit in deep sleep
	task automatic sc_deep_layout();
		wr(OFS_DEEP_GATE, 32'hffff_ffff);
		rd(OFS_DEEP_GATE, q);
		check("deep gate readback", q, 32'h0001_201f);
		wr(OFS_RUN_CFG, 32'h0800_0000);
		@(posedge sys_clk);
		deep_sleep_mode <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(OFS_DEEP_GATE, 32'h1 << bp[i]);
			settle(2);
			check("deep field to unit", {25'h0, unit_clk_en}, 32'h1 << i);
		end
		wr(OFS_DEEP_GATE, 32'h0000_0000);
		settle(2);
		check("deep gate cleared", {25'h0, unit_clk_en}, 32'h0);
	endtask

	// run, sleep and deep sets are distinct and auto gating picks among them
	task automatic sc_mode_select();
		wr(OFS_RUN_GATE, 32'h0000_2000);
		wr(OFS_SLEEP_GATE, 32'h0000_0003);
		wr(OFS_DEEP_GATE, 32'h0001_0000);
		settle(2);
		check("deep set in deep sleep", {25'h0, unit_clk_en}, 32'h40);
		@(posedge sys_clk);
		sleep_mode <= 1'b1;
		settle(2);
		check("deep wins over sleep", {25'h0, unit_clk_en}, 32'h40);
		@(posedge sys_clk);
		deep_sleep_mode <= 1'b0;
		settle(2);
		check("sleep set in sleep", {25'h0, unit_clk_en}, 32'h03);
		wr(OFS_RUN_CFG, 32'h0000_0000);
		settle(2);
		check("run set without auto", {25'h0, unit_clk_en}, 32'h20);
		// read-modify-write keeps reserved bits as read; enables port e under the run set
		rd(OFS_RUN_GATE, q);
		wr(OFS_RUN_GATE, q | 32'h0000_0010);
		settle(2);
		check("run set change on edge", {25'h0, unit_clk_en}, 32'h30);
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
	endtask

	// an access to an unclocked unit faults, latches status and raises irq
	task automatic sc_fault_irq();
		@(posedge sys_clk);
		unit_acc_valid <= 7'h22;
		#1;
		check("fault on gated unit", {25'h0, unit_acc_fault}, 32'h02);
		@(posedge sys_clk);
		unit_acc_valid <= 7'h00;
		settle(1);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h0000_0002);
		settle(1);
		check("irq enabled", {31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h0000_0000);
		rd(OFS_IRQ_STATUS, q);
		check("status sticky", q, 32'h0000_0002);
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		settle(1);
		check("irq cleared", {31'h0, irq}, 32'h0);
		// a fault that stands through the clear edge must survive it
		@(posedge sys_clk);
		unit_acc_valid <= 7'h01;
		wr(OFS_IRQ_CLEAR, 32'h0000_0001);
		unit_acc_valid <= 7'h00;
		rd(OFS_IRQ_STATUS, q);
		check("set wins over clear", q, 32'h0000_0001);
		wr(OFS_IRQ_CLEAR, 32'h0000_0001);
		rd(OFS_IRQ_STATUS, q);
		check("clear without event", q, 32'h0000_0000);
	endtask

	// capability bits mask writes; set bits hold units in reset until cleared
	task automatic sc_soft_reset();
		wr(OFS_SOFT_RESET, 32'hffff_ffff);
		rd(OFS_SOFT_RESET, q);
		check("soft reset readback", q, 32'h0101_0048);
		check("all units held", rst_outs(), 32'hf);
		// only byte lane zero written: hibernation and watchdog released, can and adc held
		@(posedge sys_clk);
		pstrb <= 4'h1;
		wr(OFS_SOFT_RESET, 32'h0000_0000);
		settle(0);
		check("lane zero only", rst_outs(), 32'hc);
		@(posedge sys_clk);
		pstrb <= 4'hf;
		wr(OFS_SOFT_RESET, 32'h0000_0000);
		settle(0);
		check("units released", rst_outs(), 32'h0);
		@(posedge sys_clk);
		capability_register_one <= 32'h0000_0008;
		wr(OFS_SOFT_RESET, 32'hffff_ffff);
		rd(OFS_SOFT_RESET, q);
		check("masked write", q, 32'h0000_0008);
		check("watchdog alone held", rst_outs(), 32'h1);
	endtask

	task automatic sc_unmapped_and_rereset();
		logic e;
		apb(1'b0, 12'h044, 32'h0, q, e);
		check("unmapped read error", {31'h0, e}, 32'h1);
		check("unmapped read data", q, 32'h0);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		#1;
		check("reset outs cleared", rst_outs(), 32'h0);
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(OFS_SOFT_RESET, q);
		check("soft reset after rereset", q, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		sleep_mode = 1'b0;
		deep_sleep_mode = 1'b0;
		capability_register_one = 32'hffff_ffff;
		unit_acc_valid = 7'h00;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		sc_reset_values();
		sc_deep_layout();
		sc_mode_select();
		sc_fault_irq();
		sc_soft_reset();
		sc_unmapped_and_rereset();
		complete_run();
	end
endmodule
`default_nettype wire
